/* File: hw/prc_pkg.sv */
// Purpose: constants for the transceiver reset, carrier, link and loopback control block
// Assumes: core_clk at 100 MHz, AXI4-Lite register access with 32-bit data
// Notes:   register offsets are byte addresses of aligned words
package prc_pkg;
   // clock
   localparam int unsigned CLK_MHZ            = 100;
   // timing, figures in their own units
   localparam int unsigned MAC_SLOW_US        = 16;
   localparam int unsigned LINK_SETTLE_US     = 330;
   localparam int unsigned SOFT_RESET_MAX_MS  = 500;
   localparam int unsigned MAC_SLOW_CYC       = MAC_SLOW_US * CLK_MHZ;
   localparam int unsigned LINK_SETTLE_CYC    = LINK_SETTLE_US * CLK_MHZ;
   localparam int unsigned SOFT_RESET_CYC_DEF = 64;
   // rmii-side rates: divide core clock to 2.5 MHz and 25 MHz enables
   localparam int unsigned DIV_SLOW           = CLK_MHZ * 10 / 25;
   localparam int unsigned DIV_FAST           = CLK_MHZ / 25;
   // register byte offsets
   localparam logic [7:0] REG_CTRL            = 8'h00;
   localparam logic [7:0] REG_STATUS          = 8'h04;
   localparam logic [7:0] REG_MODE            = 8'h08;
   // control register fields
   localparam int unsigned CTRL_SOFT_RESET    = 15;
   localparam int unsigned CTRL_LOOPBACK      = 14;
   localparam int unsigned CTRL_AUTONEG       = 12;
   localparam int unsigned CTRL_POWER_DOWN    = 11;
   localparam int unsigned CTRL_DUPLEX        = 8;
   localparam logic [31:0] CTRL_RESET         = 32'h0000_1000;
   // status register fields
   localparam int unsigned STAT_LINK          = 2;
   localparam int unsigned STAT_CARRIER       = 3;
   localparam int unsigned STAT_FAST_CLK      = 4;
   localparam int unsigned STAT_LINK_STATE    = 8;
   // mode register fields
   localparam int unsigned MODE_FAR_LOOP      = 9;
   localparam int unsigned MODE_REPEATER      = 8;
   localparam int unsigned MODE_SPEED10       = 4;
   localparam int unsigned MODE_ED_POWER_DOWN = 13;
   localparam int unsigned MODE_IMMUNE        = 0;
   localparam logic [31:0] MODE_RESET         = 32'h0000_0000;
   // axi responses
   localparam logic [1:0] RESP_OKAY           = 2'b00;
   localparam logic [1:0] RESP_SLVERR         = 2'b10;
   // 4b/5b code groups
   localparam logic [4:0] SYM_IDLE            = 5'h1f;
   localparam logic [4:0] SYM_J               = 5'h18;
   localparam logic [4:0] SYM_K               = 5'h11;
   localparam logic [4:0] SYM_T               = 5'h0d;
   localparam logic [4:0] SYM_R               = 5'h07;
   // carrier window
   localparam int unsigned CRS_SPAN           = 10;
   typedef enum logic [1:0] {PRC_LINK_DOWN, PRC_LINK_SETTLE, PRC_LINK_READY, PRC_LINK_UP} prc_link_e;
   typedef enum logic [2:0] {PRC_CS_IDLE, PRC_CS_PRE, PRC_CS_STREAM, PRC_CS_AFTER_T,
                             PRC_CS_AFTER_I} prc_cs_e;
endpackage

/* File: hw/prc_ctrl.sv */
// Purpose: reset, carrier sense, link monitor and loopback steering of a 10/100 transceiver
// Assumes: one clock core_clk; line bits arrive one per rx_bit_valid pulse, unscrambled
// Notes:   registers over AXI4-Lite; bit-level coding and analog paths live outside
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module prc_ctrl
   import prc_pkg::*;
#(
   parameter int unsigned SETTLE_CYC     = LINK_SETTLE_CYC,
   parameter int unsigned SOFT_RESET_CYC = SOFT_RESET_CYC_DEF
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        hw_reset_n,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // line side inputs
   input  wire logic        line_valid,
   input  wire logic        autoneg_enable_grant,
   input  wire logic        link10_status,
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic        tx_active,
   // mac side data
   input  wire logic [1:0]  mac_txd,
   input  wire logic        mac_txen,
   input  wire logic [1:0]  line_rxd,
   input  wire logic        line_rx_valid,
   // outputs
   output logic             mac_clk_en,
   output logic             carrier_data_valid,
   output logic [1:0]       mac_rxd,
   output logic [1:0]       line_txd,
   output logic             line_txen,
   output logic             line_tx_power_en,
   output logic             link_activity_led,
   output logic             link_datapath_active,
   output logic             soft_reset_active
);
   // hardware reset pin synchroniser
   logic                     hwr_s1_r;
   logic                     hwr_s2_r;
   logic                     hw_rst;
   // software reset
   logic                     sreset_r;
   logic [31:0]              scnt_r;
   logic                     core_rst;
   // registers
   logic [31:0]              ctrl_r;
   logic [31:0]              mode_r;
   // axi
   logic                     aw_have_r;
   logic                     w_have_r;
   logic [7:0]               awaddr_r;
   logic [31:0]              wdata_r;
   logic [3:0]               wstrb_r;
   logic [31:0]              wmerged;
   logic [31:0]              rd_val;
   logic                     rd_hit;
   logic                     wr_fire;
   // link
   prc_link_e                link_r;
   logic [31:0]              lcnt_r;
   logic                     link100;
   logic                     link_ok;
   // carrier
   prc_cs_e                  cs_r;
   logic [CRS_SPAN-1:0]      win_r;
   logic [4:0]               sym_r;
   logic [2:0]               bcnt_r;
   logic [3:0]               ones_r;
   logic                     rx_carrier_r;
   logic                     crs;
   logic [CRS_SPAN-1:0]      win_nxt;
   logic [4:0]               sym_nxt;
   logic                     two_sep_zeros;
   // mac rate
   logic [31:0]              slow_cnt_r;
   logic                     fast_r;
   logic [7:0]               div_r;
   logic [7:0]               div_top;
   // led blink and loopback selects
   logic [23:0]              blink_r;
   logic                     far_loop;
   logic                     near_loop;

   always_ff @(posedge core_clk) begin
      hwr_s1_r <= hw_reset_n;
      hwr_s2_r <= hwr_s1_r;
   end
   // the pin is trusted low for its full minimum width by the host
   assign hw_rst   = rst | ~hwr_s2_r;
   assign core_rst = hw_rst | sreset_r;

   // axi write side
   assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
   assign wr_fire       = aw_have_r & w_have_r & ~s_axi_bvalid;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_have_r    <= 1'b0;
         w_have_r     <= 1'b0;
         awaddr_r     <= 8'h00;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == REG_CTRL || awaddr_r == REG_MODE) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // control register: power-down bits are plain storage, nothing resets on them
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_fire && awaddr_r == REG_CTRL) begin
         ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
         ctrl_r[CTRL_SOFT_RESET] <= 1'b0;
      end
   end
   assign wmerged = merge(ctrl_r, wdata_r, wstrb_r);

   // mode register: immune bit survives soft reset
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         mode_r <= MODE_RESET;
      end else if (sreset_r) begin
         mode_r <= MODE_RESET;
         mode_r[MODE_IMMUNE] <= mode_r[MODE_IMMUNE];
      end else if (wr_fire && awaddr_r == REG_MODE) begin
         mode_r <= merge(mode_r, wdata_r, wstrb_r);
      end
   end

   // soft reset: a fixed short pulse, far inside the half-second bound
   always_ff @(posedge core_clk) begin
      if (hw_rst) begin
         sreset_r <= 1'b0;
         scnt_r   <= 32'h0;
      end else if (sreset_r) begin
         if (scnt_r == SOFT_RESET_CYC - 1) begin
            sreset_r <= 1'b0;
            scnt_r   <= 32'h0;
         end else begin
            scnt_r <= scnt_r + 32'h1;
         end
      end else if (wr_fire && awaddr_r == REG_CTRL && wmerged[CTRL_SOFT_RESET]) begin
         sreset_r <= 1'b1;
      end
   end
   assign soft_reset_active = sreset_r;

   // axi read side
   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         REG_CTRL: begin
            rd_val = ctrl_r;
            rd_val[CTRL_SOFT_RESET] = sreset_r;
         end
         REG_STATUS: begin
            rd_val[STAT_LINK]       = link_ok;
            rd_val[STAT_CARRIER]    = crs;
            rd_val[STAT_FAST_CLK]   = fast_r;
            rd_val[STAT_LINK_STATE +: 2] = link_r;
         end
         REG_MODE: rd_val = mode_r;
         default:  rd_hit = 1'b0;
      endcase
   end
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // link monitor
   always_ff @(posedge core_clk) begin
      if (core_rst || !line_valid) begin
         link_r <= PRC_LINK_DOWN;
         lcnt_r <= 32'h0;
      end else begin
         case (link_r)
            PRC_LINK_DOWN: begin
               link_r <= PRC_LINK_SETTLE;
               lcnt_r <= 32'h1;
            end
            PRC_LINK_SETTLE: begin
               if (lcnt_r >= SETTLE_CYC) begin
                  link_r <= ctrl_r[CTRL_AUTONEG] ? PRC_LINK_READY : PRC_LINK_UP;
               end else begin
                  lcnt_r <= lcnt_r + 32'h1;
               end
            end
            PRC_LINK_READY: if (autoneg_enable_grant || !ctrl_r[CTRL_AUTONEG]) link_r <= PRC_LINK_UP;
            PRC_LINK_UP: link_r <= PRC_LINK_UP;
            default: link_r <= PRC_LINK_DOWN;
         endcase
      end
   end
   assign link100 = (link_r == PRC_LINK_UP) && line_valid;
   assign link_ok = mode_r[MODE_SPEED10] ? link10_status : link100;
   assign link_datapath_active = link100;

   // carrier detection on unscrambled code bits
   assign win_nxt = {win_r[CRS_SPAN-2:0], rx_bit};
   assign sym_nxt = {sym_r[3:0], rx_bit};
   always_comb begin
      two_sep_zeros = 1'b0;
      for (int i = 0; i < CRS_SPAN; i++) begin
         for (int j = i + 2; j < CRS_SPAN; j++) begin
            if (!win_nxt[i] && !win_nxt[j]) two_sep_zeros = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         cs_r         <= PRC_CS_IDLE;
         win_r        <= {CRS_SPAN{1'b1}};
         sym_r        <= SYM_IDLE;
         bcnt_r       <= 3'h0;
         ones_r       <= 4'h0;
         rx_carrier_r <= 1'b0;
      end else if (rx_bit_valid) begin
         win_r  <= win_nxt;
         sym_r  <= sym_nxt;
         ones_r <= rx_bit ? ((ones_r == 4'(CRS_SPAN)) ? ones_r : ones_r + 4'h1) : 4'h0;
         case (cs_r)
            PRC_CS_IDLE: if (two_sep_zeros) begin
               cs_r         <= PRC_CS_PRE;
               rx_carrier_r <= 1'b1;
               bcnt_r       <= 3'h0;
            end
            PRC_CS_PRE: begin
               if (rx_bit && ones_r == 4'(CRS_SPAN - 1)) begin
                  cs_r         <= PRC_CS_IDLE;
                  rx_carrier_r <= 1'b0;
               end else if (win_nxt == {SYM_J, SYM_K}) begin
                  cs_r   <= PRC_CS_STREAM;
                  bcnt_r <= 3'h0;
               end
            end
            default: begin
               // stream states walk one symbol per five bits
               if (bcnt_r == 3'h4) begin
                  bcnt_r <= 3'h0;
                  if (cs_r == PRC_CS_STREAM) begin
                     if (sym_nxt == SYM_T || sym_nxt == SYM_IDLE) begin
                        rx_carrier_r <= 1'b0;
                        cs_r <= (sym_nxt == SYM_T) ? PRC_CS_AFTER_T : PRC_CS_AFTER_I;
                     end
                  end else if ((cs_r == PRC_CS_AFTER_T && sym_nxt == SYM_R) ||
                               (cs_r == PRC_CS_AFTER_I && sym_nxt == SYM_IDLE)) begin
                     cs_r <= PRC_CS_IDLE;
                     // drop delimiter zeros, else idle retriggers
                     win_r <= {CRS_SPAN{1'b1}};
                  end else begin
                     rx_carrier_r <= 1'b1;
                     cs_r         <= PRC_CS_STREAM;
                  end
               end else begin
                  bcnt_r <= bcnt_r + 3'h1;
               end
            end
         endcase
      end
   end
   assign crs = (mode_r[MODE_REPEATER] || ctrl_r[CTRL_DUPLEX]) ? rx_carrier_r
                : (rx_carrier_r | tx_active);

   // mac clock rate after reset
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         slow_cnt_r <= 32'h0;
         fast_r     <= 1'b0;
      end else if (slow_cnt_r < MAC_SLOW_CYC) begin
         slow_cnt_r <= slow_cnt_r + 32'h1;
      end else begin
         fast_r <= ctrl_r[CTRL_AUTONEG];
      end
   end
   assign div_top = fast_r ? 8'(DIV_FAST - 1) : 8'(DIV_SLOW - 1);
   always_ff @(posedge core_clk) begin
      if (core_rst || div_r >= div_top) div_r <= 8'h00;
      else div_r <= div_r + 8'h01;
   end
   always_ff @(posedge core_clk) begin
      if (core_rst) mac_clk_en <= 1'b0;
      else mac_clk_en <= (div_r == div_top);
   end

   // loopback steering and outputs
   assign near_loop = ctrl_r[CTRL_LOOPBACK];
   assign far_loop  = mode_r[MODE_FAR_LOOP];
   always_ff @(posedge core_clk) begin
      if (core_rst) begin
         mac_rxd            <= 2'b00;
         line_txd           <= 2'b00;
         line_txen          <= 1'b0;
         line_tx_power_en   <= 1'b0;
         carrier_data_valid <= 1'b0;
         blink_r            <= 24'h0;
         link_activity_led  <= 1'b0;
      end else begin
         blink_r <= blink_r + 24'h1;
         link_activity_led <= link_ok & ~(crs & blink_r[23]);
         line_tx_power_en  <= ~near_loop;
         if (far_loop) begin
            line_txd           <= line_rxd;
            line_txen          <= line_rx_valid;
            mac_rxd            <= 2'b00;
            carrier_data_valid <= 1'b0;
         end else if (near_loop) begin
            line_txd           <= 2'b00;
            line_txen          <= 1'b0;
            mac_rxd            <= mac_txd;
            carrier_data_valid <= mac_txen;
         end else begin
            line_txd           <= mac_txd;
            line_txen          <= mac_txen & link100;
            mac_rxd            <= line_rxd;
            carrier_data_valid <= crs;
         end
      end
   end
endmodule

/* File: bench/prc_ctrl_props.sv */
// Purpose: port-level checks on prc_ctrl
// Assumes: parameters handed on by the bind
// Notes:   long spans are counted in helper logic, not unrolled
`timescale 1ns/1ps
module prc_ctrl_props
   import prc_pkg::*;
#(
   parameter int unsigned SETTLE_CYC     = 20,
   parameter int unsigned SOFT_RESET_CYC = 8
) (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        line_valid,
   input wire logic        link_datapath_active,
   input wire logic        mac_clk_en,
   input wire logic        soft_reset_active
);
   int unsigned lv_cnt;
   int unsigned sr_cnt;
   int unsigned gap;
   int unsigned up_cnt;
   logic        seen;
   always_ff @(posedge core_clk) begin
      lv_cnt <= (rst || !line_valid) ? 0 : (lv_cnt < SETTLE_CYC ? lv_cnt + 1 : lv_cnt);
   end
   always_ff @(posedge core_clk) begin
      sr_cnt <= (rst || !soft_reset_active) ? 0 : sr_cnt + 1;
   end
   // gap only means something once a first pulse has been seen
   always_ff @(posedge core_clk) begin
      gap    <= mac_clk_en ? 0 : gap + 1;
      seen   <= rst ? 1'b0 : (seen | mac_clk_en);
      up_cnt <= rst ? 0 : (up_cnt < MAC_SLOW_CYC ? up_cnt + 1 : up_cnt);
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_link_drop; !line_valid |=> !link_datapath_active; endproperty
   a_link_drop: assert property (p_link_drop) else $error("link kept without line valid");
   property p_link_settle; link_datapath_active |-> lv_cnt >= SETTLE_CYC - 1; endproperty
   a_link_settle: assert property (p_link_settle) else $error("link up before settle time");
   property p_sr_len; $fell(soft_reset_active) |-> sr_cnt == SOFT_RESET_CYC; endproperty
   a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
   property p_sr_bound; sr_cnt <= SOFT_RESET_CYC; endproperty
   a_sr_bound: assert property (p_sr_bound) else $error("soft reset overran");
   property p_clk_pulse; mac_clk_en |=> !mac_clk_en; endproperty
   a_clk_pulse: assert property (p_clk_pulse) else $error("rate enable wider than one cycle");
   property p_clk_slow; mac_clk_en && seen && up_cnt < MAC_SLOW_CYC |-> gap == DIV_SLOW - 1; endproperty
   a_clk_slow: assert property (p_clk_slow) else $error("early rate not slow");
   c_sr: cover property ($fell(soft_reset_active));
   c_link: cover property ($rose(link_datapath_active));
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind prc_ctrl prc_ctrl_props #(.SETTLE_CYC(SETTLE_CYC), .SOFT_RESET_CYC(SOFT_RESET_CYC)) u_props (.core_clk, .rst,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .line_valid, .link_datapath_active, .mac_clk_en, .soft_reset_active);

/* File: bench/prc_mac_model.sv */
// Purpose: mac transmit side facing prc_ctrl
// Assumes: data moves only on rate enables
// Notes:   idle data pins toggle so a stale value is never trusted
`timescale 1ns/1ps
module prc_mac_model (
   // clock and pacing
   input  wire logic       core_clk,
   input  wire logic       mac_clk_en,
   // bench control
   input  wire logic       tx_go,
   input  wire logic [1:0] tx_data,
   // transmit pins
   output logic [1:0]      mac_txd,
   output logic            mac_txen
);
   initial begin
      mac_txd = 2'b00;
      mac_txen = 1'b0;
   end
   always @(posedge core_clk) begin
      if (mac_clk_en) begin
         mac_txen <= tx_go;
         mac_txd <= tx_go ? tx_data : ~mac_txd;
      end
   end
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for prc_ctrl
// Assumes: short settle and soft reset counts; all byte lanes written
// Notes:   code bits go msb first, two cycles per bit
`timescale 1ns/1ps
module tb_top;
   import prc_pkg::*;
   localparam int unsigned SETTLE = 20;
   logic core_clk, rst, hw_reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, line_valid, link10_status;
   logic autoneg_enable_grant, rx_bit, rx_bit_valid, tx_active, mac_txen, line_rx_valid, mac_clk_en, tx_go;
   logic carrier_data_valid, line_txen, line_tx_power_en, link_activity_led, link_datapath_active, soft_reset_active;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [1:0]  s_axi_bresp, s_axi_rresp, mac_txd, line_rxd, mac_rxd, line_txd, tx_data;
   logic [3:0]  s_axi_wstrb;
   int          n_mismatch, checks_done;
   prc_ctrl #(.SETTLE_CYC(SETTLE), .SOFT_RESET_CYC(8)) u_dut (.core_clk, .rst, .hw_reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_valid, .autoneg_enable_grant, .link10_status, .rx_bit, .rx_bit_valid,
      .tx_active, .mac_txd, .mac_txen, .line_rxd, .line_rx_valid, .mac_clk_en, .carrier_data_valid, .mac_rxd,
      .line_txd, .line_txen, .line_tx_power_en, .link_activity_led, .link_datapath_active, .soft_reset_active);
   prc_mac_model u_mac (.core_clk, .mac_clk_en, .tx_go, .tx_data, .mac_txd, .mac_txen);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hang;
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i <= 100; i++) begin
         if (i == 100) hang;
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      chk(32'(s_axi_bresp), 32'(RESP_OKAY));
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i <= 100; i++) begin
         if (i == 100) hang;
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic gap(input int e);
      int n;
      for (n = 0; n < 300 && mac_clk_en !== 1'b1; n++) @(posedge core_clk);
      @(posedge core_clk);
      for (n = 1; n < 300 && mac_clk_en !== 1'b1; n++) @(posedge core_clk);
      chk(32'(n), 32'(e));
   endtask
   task automatic sym(input logic [4:0] s);
      for (int i = 4; i >= 0; i--) begin
         @(posedge core_clk);
         rx_bit <= s[i];
         rx_bit_valid <= 1'b1;
         @(posedge core_clk);
         rx_bit_valid <= 1'b0;
      end
   endtask
   // clock never stops, hardware reset included
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          i;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, line_valid, link10_status} = '0;
      {autoneg_enable_grant, rx_bit_valid, tx_active, line_rx_valid, tx_go, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, line_rxd, tx_data} = '0;
      s_axi_wstrb = 4'hf;
      rx_bit = 1'b1;
      seed = 32'h7ffbae5e;
      rst = 1'b1;
      hw_reset_n = 1'b0;
      n_mismatch = 0;
      checks_done = 0;
      tick(4);
      rst <= 1'b0;
      hw_reset_n <= 1'b1;
      rd(REG_CTRL, d, r); chk(d, CTRL_RESET);
      rd(REG_MODE, d, r); chk(d, MODE_RESET);
      rd(8'h0c, d, r); chk(32'(r), 32'(RESP_SLVERR));
      gap(DIV_SLOW);
      tick(MAC_SLOW_CYC);
      gap(DIV_FAST);
      $display("rate test done");
      tx_active <= 1'b1;
      tick(3); chk(32'(carrier_data_valid), 1);
      wr(REG_CTRL, CTRL_RESET | 32'h1 << CTRL_DUPLEX);
      tick(3); chk(32'(carrier_data_valid), 0);
      wr(REG_CTRL, CTRL_RESET); wr(REG_MODE, 32'h1 << MODE_REPEATER); tick(3); chk(32'(carrier_data_valid), 0);
      tx_active <= 1'b0;
      sym(5'h15); tick(3); chk(32'(carrier_data_valid), 1);
      sym(SYM_IDLE); sym(SYM_IDLE); tick(3); chk(32'(carrier_data_valid), 0);
      sym(SYM_J); sym(SYM_K); sym(5'h1e); tick(3); chk(32'(carrier_data_valid), 1);
      sym(SYM_T); sym(5'h1e); sym(SYM_IDLE); sym(5'h1e); tick(3); chk(32'(carrier_data_valid), 1);
      sym(SYM_T); sym(SYM_R); sym(SYM_IDLE); tick(3); chk(32'(carrier_data_valid), 0);
      $display("carrier test done");
      wr(REG_CTRL, CTRL_RESET);
      line_valid <= 1'b1;
      tick(SETTLE + 10); chk(32'(link_datapath_active), 0);
      autoneg_enable_grant <= 1'b1;
      tick(3); chk(32'(link_datapath_active), 1);
      chk(32'(link_activity_led), 1);
      line_valid <= 1'b0;
      tick(2); chk(32'(link_activity_led), 0);
      wr(REG_CTRL, 32'h0);
      autoneg_enable_grant <= 1'b0;
      line_valid <= 1'b1;
      tick(SETTLE + 10); chk(32'(link_datapath_active), 1);
      line_valid <= 1'b0;
      wr(REG_MODE, 32'h1 << MODE_SPEED10);
      link10_status <= 1'b1;
      rd(REG_STATUS, d, r); chk(32'(d[STAT_LINK]), 1);
      $display("link test done");
      wr(REG_MODE, 32'h0);
      wr(REG_CTRL, CTRL_RESET | 32'h1 << CTRL_LOOPBACK);
      tx_go <= 1'b1;
      repeat (4) begin
         seed = lfsr(seed);
         tx_data <= seed[1:0];
         tick(16); chk(32'(mac_rxd), 32'(seed[1:0]));
         chk(32'(line_tx_power_en), 0);
      end
      wr(REG_CTRL, CTRL_RESET);
      wr(REG_MODE, 32'h1 << MODE_FAR_LOOP);
      line_rx_valid <= 1'b1;
      repeat (4) begin
         seed = lfsr(seed);
         line_rxd <= seed[3:2];
         tick(4); chk(32'(line_txd), 32'(seed[3:2]));
         chk(32'(carrier_data_valid), 0);
         chk(32'(line_txen), 1);
         chk(32'(line_tx_power_en), 1);
      end
      $display("loopback test done");
      wr(REG_MODE, 32'h1 << MODE_IMMUNE | 32'h1 << MODE_FAR_LOOP);
      wr(REG_CTRL, 32'h1 << CTRL_SOFT_RESET);
      rd(REG_CTRL, d, r); chk(32'(d[CTRL_SOFT_RESET]), 1);
      for (i = 0; i < 50 && soft_reset_active !== 1'b0; i++) @(posedge core_clk);
      chk(32'(soft_reset_active), 0);
      rd(REG_CTRL, d, r); chk(d, CTRL_RESET);
      rd(REG_MODE, d, r); chk(d, 32'h1 << MODE_IMMUNE);
      wr(REG_CTRL, 32'h1 << CTRL_POWER_DOWN);
      wr(REG_CTRL, CTRL_RESET);
      rd(REG_MODE, d, r); chk(d, 32'h1 << MODE_IMMUNE);
      hw_reset_n <= 1'b0;
      tick(4);
      hw_reset_n <= 1'b1;
      tick(4);
      rd(REG_MODE, d, r); chk(d, MODE_RESET);
      $display("reset test done");
      final_report;
   end
endmodule
